/* cfst_top.sv */
// CAN frame servicing, pin polarity, bit timing and transmit path
// How it works
// - Drive transmit pin, sample receive pin
// - Separate polarity flags for both pins
// - Hidden buffer copy takes 17 clocks
// - Each remote-state update costs 3 clocks
// - Scheduling one transmission takes 2 clocks
// - Message memory access stalls servicing counts
// - Servicing must end within four bit gap; longer servicing is not cut short, it only sets the sticky overrun flag
// - Bit timing minimums: prescaler 2, 2, 1
// - Bit is sync+seg1+seg2 quanta times prescaler
// - Masks cover all 32 identifier/control bits
// - Passed remote frame answered with data frame if a buffer is transmit-on-remote
// - Answering data frame accepted via same filter
`timescale 1ns/1ns
module cfst_top import cfst_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Bus pins toward the transceiver
  input wire logic BUS_RECEIVE_PIN,
  output logic BUS_TRANSMIT_PIN,
  // Frames from the receive logic
  input wire logic FRAME_VALID,
  input wire cfst_frame_t FRAME,
  // Answers toward the transmit logic
  output logic ANSWER_VALID,
  output cfst_frame_t ANSWER,
  output logic [NBUF-1:0] ANSWER_BUF,
  output logic BUSY
);
  // ==========================================
  // Registers
  logic [2:0] cfg_r; // Enable and polarity flags
  cfst_tim_t tim_r; // Bit timing
  logic [31:0] global_acceptance_mask_r; // 1 = bit compared
  logic [31:0] basic_acceptance_mask_r; // 1 = bit compared
  logic [31:0] acc_r; // Acceptance identifier
  logic [NBUF-1:0] ror_r; // Transmit-on-remote states
  logic [NBUF-1:0] once_r; // Transmit-once-on-remote states
  logic late_r; // Gap overrun, sticky
  logic [31:0] prdata_r; // Read data
  logic [31:0] rd_mux; // Read selection
  logic wr; // Register write strobe
  logic txd_req; // Access to the FIFO word
  logic mapped; // Address decodes
  // Servicing
  cfst_state_t st_r; // Sequencer state
  cfst_state_t st_nxt; // Next state
  logic [4:0] cnt_r; // Cycles left in step
  logic [NBUF-1:0] pend_r; // Buffers still to update
  logic [NBUF-1:0] low; // Lowest pending buffer
  logic [NBUF-1:0] first_r; // Buffer to answer from
  cfst_frame_t frm_r; // Captured frame
  logic [15:0] gap_r; // Clocks left in gap
  logic [15:0] bitclk; // Clocks per bit
  logic pass; // Frame passes a mask
  logic take; // Frame accepted for service
  logic step; // Servicing may advance
  logic mem_wait; // CPU in message memory
  logic last; // Last cycle of a step
  logic ans_fire; // Scheduling completes
  logic ans_v_r; // Answer pulse
  logic [NBUF-1:0] ans_buf_r; // Answer buffer
  // Transmit path
  logic f_valid; // FIFO head valid
  logic [31:0] f_data; // FIFO head
  logic f_in_ready; // FIFO has room
  logic ld; // Load shifter from FIFO
  logic act_r; // Shifter active
  logic [31:0] shift_r; // Outgoing bits, MSB first
  logic [5:0] bits_r; // Bits left
  logic [15:0] bclk_r; // Clocks left in bit
  logic tx_r; // Transmit pin flop
  logic rx_m_r; // Receive sync stage one
  logic rx_s_r; // Receive sync stage two
  logic rx_lvl; // Receive level after polarity

  // Raise timing fields that fall below the minimums
  function automatic cfst_tim_t clamp_tim(logic [14:0] w);
    cfst_tim_t t;
    t = w;
    if (t.presc < PRESC_MIN) t.presc = PRESC_MIN;
    if (t.ts1 < TS1_MIN) t.ts1 = TS1_MIN;
    if (t.ts2 < TS2_MIN) t.ts2 = TS2_MIN;
    return t;
  endfunction

  // Masked compare of a frame against the acceptance identifier
  function automatic logic hit(logic [31:0] f, logic [31:0] id, logic [31:0] m);
    return ((f ^ id) & m) == 32'h0;
  endfunction

  // ==========================================
  // APB slave
  assign txd_req = PSEL && PWRITE && PADDR == OFS_TXD;
  assign mapped = PADDR[1:0] == 2'h0 && PADDR <= OFS_TXD;
  // FIFO full holds the access phase
  assign PREADY = !(txd_req && !f_in_ready);
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign wr = CE && PSEL && PENABLE && PWRITE && PREADY;
  assign PRDATA = prdata_r;

  // Read selection
  always_comb begin
    rd_mux = 32'h0;
    case (PADDR)
      OFS_CFG: rd_mux = {29'h0, cfg_r};
      OFS_TIM: rd_mux = {17'h0, tim_r};
      OFS_GMASK: rd_mux = global_acceptance_mask_r;
      OFS_BMASK: rd_mux = basic_acceptance_mask_r;
      OFS_ACC: rd_mux = acc_r;
      OFS_BUF: rd_mux = {1'b0, once_r, 1'b0, ror_r};
      OFS_STAT: rd_mux = {bitclk, 12'h0, act_r, rx_lvl, late_r, BUSY};
      default: rd_mux = 32'h0;
    endcase
  end

  // Read data registered in the setup cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_r <= 32'h0;
    end else if (CE && PSEL && !PENABLE) begin
      prdata_r <= rd_mux;
    end
  end

  // Configuration, timing, masks
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r <= CFG_RST;
      tim_r <= TIM_RST;
      global_acceptance_mask_r <= MASK_RST;
      basic_acceptance_mask_r <= MASK_RST;
      acc_r <= ACC_RST;
    end else if (wr) begin
      case (PADDR)
        OFS_CFG: cfg_r <= PWDATA[2:0];
        OFS_TIM: tim_r <= clamp_tim(PWDATA[14:0]);
        OFS_GMASK: global_acceptance_mask_r <= PWDATA;
        OFS_BMASK: basic_acceptance_mask_r <= PWDATA;
        OFS_ACC: acc_r <= PWDATA;
        default: ;
      endcase
    end
  end

  // Buffer states: hardware update wins over software write
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ror_r <= BUF_RST;
      once_r <= BUF_RST;
    end else if (CE) begin
      if (wr && PADDR == OFS_BUF) begin
        ror_r <= PWDATA[NBUF-1:0] & ~((st_r == S_UPD && step && last) ? low : '0);
        once_r <= (once_r & ~PWDATA[BUF_ONCE_LSB +: NBUF])
                  | ((st_r == S_UPD && step && last) ? low : '0);
      end else if (st_r == S_UPD && step && last) begin
        ror_r <= ror_r & ~low;
        once_r <= once_r | low;
      end
    end
  end

  // Gap overrun flag, set wins over write-one clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      late_r <= 1'b0;
    end else if (CE) begin
      late_r <= (st_r != S_IDLE && gap_r == 16'h0)
                || (late_r && !(wr && PADDR == OFS_STAT && PWDATA[STAT_LATE]));
    end
  end

  // ==========================================
  // Acceptance and servicing sequencer
  assign bitclk = bit_clocks(tim_r);
  // Either mask may pass the frame
  assign pass = hit(FRAME, acc_r, global_acceptance_mask_r)
                || hit(FRAME, acc_r, basic_acceptance_mask_r);
  assign take = CE && cfg_r[CFG_EN] && FRAME_VALID && st_r == S_IDLE && pass;
  assign mem_wait = PSEL && PADDR == OFS_BUF;
  assign step = !mem_wait;
  assign last = cnt_r == 5'h0;
  assign low = pend_r & (~pend_r + 15'h1);
  assign ans_fire = CE && st_r == S_SCHED && step && last;
  assign BUSY = st_r != S_IDLE;

  // State register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= S_IDLE;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  // Next state: copy, updates, scheduling
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: begin
        if (take) st_nxt = S_COPY;
      end
      S_COPY: begin
        // Data frames end after the copy
        if (step && last) st_nxt = (pend_r != '0) ? S_UPD : S_IDLE;
      end
      S_UPD: begin
        if (step && last) st_nxt = ((pend_r & ~low) != '0) ? S_UPD : S_SCHED;
      end
      S_SCHED: begin
        if (step && last) st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // Step counter and pending buffers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= 5'h0;
      pend_r <= '0;
      first_r <= '0;
    end else if (CE) begin
      if (take) begin
        cnt_r <= 5'(COPY_CYC - 1);
        pend_r <= FRAME.rtr ? ror_r : '0;
      end else if (st_r != S_IDLE && step) begin
        if (!last) begin
          cnt_r <= cnt_r - 5'h1;
        end else if (st_nxt == S_UPD) begin
          cnt_r <= 5'(UPD_CYC - 1);
          if (st_r == S_UPD) pend_r <= pend_r & ~low;
          if (st_r == S_COPY) first_r <= low;
        end else if (st_nxt == S_SCHED) begin
          cnt_r <= 5'(SCHED_CYC - 1);
          pend_r <= '0;
        end
      end
    end
  end

  // Frame capture and gap countdown
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      frm_r <= '0;
      gap_r <= 16'h0;
    end else if (CE) begin
      if (take) begin
        frm_r <= FRAME;
        gap_r <= 16'(GAP_BITS) * bitclk;
      end else if (gap_r != 16'h0) begin
        gap_r <= gap_r - 16'h1;
      end
    end
  end

  // Answer: data frame with the remote bit cleared
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ans_v_r <= 1'b0;
      ANSWER <= '0;
      ans_buf_r <= '0;
    end else if (CE) begin
      ans_v_r <= ans_fire;
      if (ans_fire) begin
        ANSWER <= '{std_id: frm_r.std_id, ext_id: frm_r.ext_id,
                    srr: frm_r.srr, ide: frm_r.ide, rtr: 1'b0};
        ans_buf_r <= first_r;
      end
    end
  end
  assign ANSWER_VALID = ans_v_r;
  assign ANSWER_BUF = ans_buf_r;

  // ==========================================
  // Transmit FIFO and serialiser
  cfst_fifo #(.W(32), .D(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst_n(RST_N),
    .en(CE),
    .in_valid(PSEL && PENABLE && txd_req),
    .in_ready(f_in_ready),
    .in_data(PWDATA),
    .out_valid(f_valid),
    .out_ready(ld),
    .out_data(f_data)
  );
  assign ld = !act_r && f_valid && cfg_r[CFG_EN];

  // Shift one word out, one bit per bit time
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      act_r <= 1'b0;
      shift_r <= 32'h0;
      bits_r <= 6'h0;
      bclk_r <= 16'h0;
    end else if (CE) begin
      if (ld) begin
        act_r <= 1'b1;
        shift_r <= f_data;
        bits_r <= 6'h20;
        bclk_r <= bitclk - 16'h1;
      end else if (act_r) begin
        if (bclk_r != 16'h0) begin
          bclk_r <= bclk_r - 16'h1;
        end else if (bits_r == 6'h1) begin
          act_r <= 1'b0;
        end else begin
          shift_r <= {shift_r[30:0], 1'b0};
          bits_r <= bits_r - 6'h1;
          bclk_r <= bitclk - 16'h1;
        end
      end
    end
  end

  // Transmit pin, recessive 1 when idle, then polarity
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_r <= 1'b1;
    end else if (CE) begin
      tx_r <= (act_r ? shift_r[31] : 1'b1) ^ cfg_r[CFG_TXPOL];
    end
  end
  assign BUS_TRANSMIT_PIN = tx_r;

  // Receive pin synchroniser
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
    end else if (CE) begin
      rx_m_r <= BUS_RECEIVE_PIN;
      rx_s_r <= rx_m_r;
    end
  end
  assign rx_lvl = rx_s_r ^ cfg_r[CFG_RXPOL];

  // ==========================================
  // Assertions
  logic [4:0] prod_r; // Productive cycles in a step
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prod_r <= 5'h0;
    end else if (CE) begin
      if (take || (st_r != S_IDLE && step && last)) prod_r <= 5'h0;
      else if (st_r != S_IDLE && step) prod_r <= prod_r + 5'h1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N || !CE);

  sequence s_copy_end;
    st_r == S_COPY && step && last;
  endsequence
  sequence s_upd_end;
    st_r == S_UPD && step && last && (pend_r & ~low) == '0;
  endsequence

  property p_tx_pol;
    ld |=> ##1 BUS_TRANSMIT_PIN == ($past(f_data[31], 2) ^ $past(cfg_r[CFG_TXPOL]));
  endproperty
  a_tx_pol: assert property (p_tx_pol) else $error("tx pin not first bit");
  property p_copy;
    s_copy_end |-> prod_r == COPY_CYC - 1;
  endproperty
  a_copy: assert property (p_copy) else $error("copy length wrong");
  property p_upd;
    (st_r == S_UPD && step && last) |-> prod_r == UPD_CYC - 1 && low != '0;
  endproperty
  a_upd: assert property (p_upd) else $error("update length wrong");
  property p_sched;
    ans_fire |-> prod_r == SCHED_CYC - 1 ##1 ANSWER_VALID;
  endproperty
  a_sched: assert property (p_sched) else $error("schedule length wrong");
  property p_wait;
    (st_r != S_IDLE && mem_wait) |=> $stable(cnt_r) && $stable(pend_r);
  endproperty
  a_wait: assert property (p_wait) else $error("servicing advanced in wait");
  property p_gap;
    (st_r != S_IDLE && gap_r == 16'h0) |=> late_r;
  endproperty
  a_gap: assert property (p_gap) else $error("overrun not flagged");
  property p_tim;
    tim_r.presc >= PRESC_MIN && tim_r.ts1 >= TS1_MIN && tim_r.ts2 >= TS2_MIN;
  endproperty
  a_tim: assert property (p_tim) else $error("timing below minimum");
  property p_bit;
    ld |=> bclk_r == bitclk - 16'h1 && bitclk >= 16'h8;
  endproperty
  a_bit: assert property (p_bit) else $error("bit length wrong");
  property p_filt;
    (FRAME_VALID && st_r == S_IDLE && !pass) |=> st_r == S_IDLE;
  endproperty
  a_filt: assert property (p_filt) else $error("unmatched frame taken");
  property p_ans;
    ANSWER_VALID |-> !ANSWER.rtr && $past(st_r) == S_SCHED;
  endproperty
  a_ans: assert property (p_ans) else $error("answer not a data frame");
  property p_data;
    (take && !FRAME.rtr) |=> pend_r == '0;
  endproperty
  a_data: assert property (p_data) else $error("data frame updated buffers");
  property p_order;
    s_upd_end |=> st_r == S_SCHED;
  endproperty
  a_order: assert property (p_order) else $error("service order broken");
endmodule // cfst_top

/* cfst_pkg.sv */
// Constants and types of the CAN frame-servicing and timing block
package cfst_pkg;
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00; // Global configuration
  localparam logic [7:0] OFS_TIM = 8'h04; // Bit timing
  localparam logic [7:0] OFS_GMASK = 8'h08; // Global acceptance mask
  localparam logic [7:0] OFS_BMASK = 8'h0c; // Basic acceptance mask
  localparam logic [7:0] OFS_ACC = 8'h10; // Acceptance identifier
  localparam logic [7:0] OFS_BUF = 8'h14; // Buffer remote states
  localparam logic [7:0] OFS_STAT = 8'h18; // Status
  localparam logic [7:0] OFS_TXD = 8'h1c; // Transmit word into FIFO
  // ==========================================
  // Field positions
  localparam int CFG_EN = 0; // Controller enable
  localparam int CFG_TXPOL = 1; // Transmit polarity flag
  localparam int CFG_RXPOL = 2; // Receive polarity flag
  localparam int BUF_ONCE_LSB = 16; // Once-on-remote states
  localparam int STAT_LATE = 1; // Servicing overran the gap
  localparam int STAT_BITCLK_LSB = 16; // Clocks per bit
  // ==========================================
  // Reset values
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [31:0] MASK_RST = 32'h0; // All bits don't care
  localparam logic [31:0] ACC_RST = 32'h0;
  localparam logic [14:0] BUF_RST = 15'h0;
  // ==========================================
  // Timing counts in controller clocks, quanta and bits; buffer count
  localparam int COPY_CYC = 17; // Hidden buffer copy
  localparam int UPD_CYC = 3; // One buffer state update
  localparam int SCHED_CYC = 2; // Transmit scheduling
  localparam int SYNC_TQ = 1; // Synchronisation segment
  localparam int GAP_BITS = 4; // Least inter-frame gap
  localparam int NBUF = 15; // Message buffers
  localparam logic [7:0] PRESC_MIN = 8'h02;
  localparam logic [3:0] TS1_MIN = 4'h2;
  localparam logic [2:0] TS2_MIN = 3'h1;
  // ==========================================
  // Types
  typedef struct packed {
    logic [10:0] std_id;
    logic [17:0] ext_id;
    logic srr;
    logic ide;
    logic rtr;
  } cfst_frame_t;
  typedef struct packed {
    logic [2:0] ts2;
    logic [3:0] ts1;
    logic [7:0] presc;
  } cfst_tim_t;
  localparam cfst_tim_t TIM_RST = '{ts2: TS2_MIN, ts1: TS1_MIN, presc: PRESC_MIN};
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_COPY = 4'h2,
    S_UPD = 4'h4,
    S_SCHED = 4'h8
  } cfst_state_t;
  // Clocks in one bit: quanta times prescaler
  function automatic logic [15:0] bit_clocks(cfst_tim_t t);
    logic [4:0] tq;
    tq = 5'(SYNC_TQ) + 5'(t.ts1) + 5'(t.ts2);
    return 16'(tq) * 16'(t.presc);
  endfunction
endpackage

/* cfst_fifo.sv */
// Transmit word FIFO with valid and ready on both sides
`timescale 1ns/1ns
module cfst_fifo import cfst_pkg::*; #(
  parameter int W = 32,
  parameter int D = 8
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  // ==========================================
  // Storage and pointers (D a power of two)
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // Word store
  logic [AW-1:0] wp_r; // Write pointer
  logic [AW-1:0] rp_r; // Read pointer
  logic [AW:0] cnt_r; // Words held
  logic push; // Word accepted
  logic pop; // Word drained

  // Honest full and empty
  assign in_ready = cnt_r != (AW+1)'(D);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
  assign push = en && in_valid && in_ready;
  assign pop = en && out_valid && out_ready;

  // Word store write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // cfst_fifo

/* cfst_xcvr_model.sv */
// Behavioural bus transceiver facing the controller's two bus pins
`timescale 1ns/1ns
module cfst_xcvr_model (
  // Controller side
  input wire logic txd,
  output logic rxd,
  // Another node forcing a dominant level
  input wire logic other_dominant
);
  // ==========================================
  // Wired-and bus: low is dominant, released bus pulls up to recessive
  logic bus_level;
  assign bus_level = txd & ~other_dominant;
  // The receiver echoes the bus level back to the controller
  assign rxd = bus_level;
endmodule // cfst_xcvr_model

/* testbench.sv */
// Self-checking bench of the frame servicing block against a bench model
`timescale 1ns/1ns
module testbench import cfst_pkg::*;;
  // ==========================================
  // Stimulus and observed signals
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic FRAME_VALID = 1'b0;
  cfst_frame_t FRAME = '0;
  logic other_dom = 1'b0;
  logic [31:0] PRDATA, rq;
  logic PREADY, PSLVERR, BUS_RECEIVE_PIN, BUS_TRANSMIT_PIN, ANSWER_VALID, BUSY, slv;
  cfst_frame_t ANSWER, ans, f;
  logic [NBUF-1:0] ANSWER_BUF, abuf, low;
  logic [31:0] rnd = 32'h69dd;
  int err_total = 0, comparisons = 0, cyc_cnt = 0;
  int w, wsum, bc, ac, n;
  // Register map and expected reset contents
  logic [7:0] ofs_tab [8] = '{OFS_CFG, OFS_TIM, OFS_GMASK, OFS_BMASK, OFS_ACC, OFS_BUF,
    OFS_STAT, OFS_TXD};
  logic [31:0] rst_tab [8] = '{32'h0, 32'h1202, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0008_0004,
    32'h0};
  logic [14:0] buf_tab [2] = '{15'h000a, 15'h7fff};
  int flip_tab [4] = '{1, 2, 3, 31};

  // ==========================================
  // Clock, design and transceiver
  always #4 CLK = ~CLK;
  cfst_top #(.FIFO_DEPTH(8)) uut (.CLK(CLK), .RST_N(RST_N), .CE(1'b1), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .BUS_RECEIVE_PIN(BUS_RECEIVE_PIN),
    .BUS_TRANSMIT_PIN(BUS_TRANSMIT_PIN), .FRAME_VALID(FRAME_VALID), .FRAME(FRAME),
    .ANSWER_VALID(ANSWER_VALID), .ANSWER(ANSWER), .ANSWER_BUF(ANSWER_BUF), .BUSY(BUSY));
  cfst_xcvr_model peer (.txd(BUS_TRANSMIT_PIN), .rxd(BUS_RECEIVE_PIN),
    .other_dominant(other_dom));

  // ==========================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Verdict and end of run
  task automatic give_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Compare a data value
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Compare a cycle count
  task automatic chk_cyc(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until PREADY is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output int wt);
    wt = 0;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && wt < 5000) begin
      wt++;
      @(posedge CLK);
    end
    if (wt == 5000) err_total++;
    q = PRDATA;
    slv = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rq, w);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, rq, w);
  endtask
  // Present one frame; count busy cycles and the cycle of the answer
  task automatic svc(input cfst_frame_t fr, output int b, output int a);
    b = 0;
    a = 0;
    FRAME <= fr;
    FRAME_VALID <= 1'b1;
    @(posedge CLK);
    FRAME_VALID <= 1'b0;
    for (int c = 1; c <= 120; c++) begin
      #1;
      if (BUSY === 1'b1) b++;
      if (ANSWER_VALID === 1'b1) begin
        a = c;
        ans = ANSWER;
        abuf = ANSWER_BUF;
      end
      @(posedge CLK);
    end
  endtask

  // ==========================================
  // Hang guard
  always @(posedge CLK) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    // Reset contents of every register
    foreach (ofs_tab[i]) begin
      rd(ofs_tab[i]);
      chk_val(rq, rst_tab[i]);
    end
    // Unmapped and misaligned places are refused
    rd(8'h20);
    chk_val({slv, rq[30:0]}, 32'h8000_0000);
    rd(8'h02);
    chk_val({slv, rq[30:0]}, 32'h8000_0000);
    // Bit length follows the timing fields; minimums are enforced
    wr(OFS_TIM, 32'h2403);
    rd(OFS_STAT);
    chk_val({16'h0, rq[31:16]}, 32'd21);
    wr(OFS_TIM, 32'h0);
    rd(OFS_TIM);
    chk_val(rq, 32'h1202);
    wr(OFS_CFG, 32'h1);
    // Remote frames answered, with buffer updates and gap overrun flag
    foreach (buf_tab[i]) begin
      n = $countones(buf_tab[i]);
      low = buf_tab[i] & (~buf_tab[i] + 15'h1);
      wr(OFS_STAT, 32'h2);
      wr(OFS_BUF, {17'h0, buf_tab[i]});
      rnd = lfsr(rnd);
      f = rnd;
      f.rtr = 1'b1;
      svc(f, bc, ac);
      chk_cyc(ac, COPY_CYC + UPD_CYC * n + SCHED_CYC + 1);
      f.rtr = 1'b0;
      chk_val(ans, f);
      chk_val({17'h0, abuf}, {17'h0, low});
      rd(OFS_BUF);
      chk_val(rq, {1'b0, buf_tab[i], 16'h0});
      rd(OFS_STAT);
      chk_val({31'h0, rq[1]}, {31'h0, ac > GAP_BITS * 8});
      wr(OFS_BUF, 32'h7fff_0000);
    end
    // Worst case at 16 clocks per bit, stalled twice by a buffer read
    wr(OFS_TIM, 32'h1204);
    wr(OFS_BUF, 32'h3fff);
    wr(OFS_STAT, 32'h2);
    f.rtr = 1'b1;
    fork
      svc(f, bc, ac);
      begin
        repeat (4) @(posedge CLK);
        rd(OFS_BUF);
      end
    join
    chk_val(rq, 32'h3fff);
    chk_cyc(ac, COPY_CYC + UPD_CYC * 14 + SCHED_CYC + 3);
    rd(OFS_STAT);
    chk_val({31'h0, rq[1]}, 32'h0);
    wr(OFS_TIM, 32'h0);
    wr(OFS_BUF, 32'h7fff_0000);
    // Data frame: copy only, no answer
    rnd = lfsr(rnd);
    f = rnd;
    f.rtr = 1'b0;
    svc(f, bc, ac);
    chk_cyc(bc, COPY_CYC);
    chk_cyc(ac, 0);
    // Remote bit left open: the data frame matching a remote identifier passes
    wr(OFS_GMASK, 32'hffff_fffe);
    wr(OFS_BMASK, 32'hffff_ffff);
    wr(OFS_ACC, 32'(f) | 32'h1);
    svc(f, bc, ac);
    chk_cyc(bc, COPY_CYC);
    // Compared bits 1, 2, 3 and 31, control bits too, each reject a frame
    foreach (flip_tab[i]) begin
      svc(cfst_frame_t'(32'(f) ^ (32'h1 << flip_tab[i])), bc, ac);
      chk_cyc(bc, 0);
    end
    // Receive level with and without inversion
    for (int i = 0; i < 4; i++) begin
      other_dom <= i[0];
      wr(OFS_CFG, {29'h0, i[1], 2'b01});
      rd(OFS_STAT);
      chk_val({31'h0, rq[2]}, {31'h0, ~i[0] ^ i[1]});
    end
    other_dom <= 1'b0;
    // Inverted transmit: idle level, then two leading zero bits MSB first
    wr(OFS_CFG, 32'h3);
    repeat (4) @(posedge CLK);
    chk_val({31'h0, BUS_TRANSMIT_PIN}, 32'h0);
    wr(OFS_TXD, 32'h3fff_ffff);
    w = 0;
    while (BUS_TRANSMIT_PIN !== 1'b1 && w < 200) begin
      w++;
      @(posedge CLK);
    end
    w = 0;
    while (BUS_TRANSMIT_PIN === 1'b1 && w < 200) begin
      w++;
      @(posedge CLK);
    end
    chk_cyc(w, 16);
    // Overfill the FIFO so that a write is held off, then drain it
    wsum = 0;
    repeat (10) begin
      apb(1'b1, OFS_TXD, 32'h3fff_ffff, rq, w);
      wsum += w;
    end
    chk_cyc(int'(wsum > 0), 1);
    for (int k = 0; k < 1500; k++) begin
      rd(OFS_STAT);
      if (rq[3] === 1'b0) rd(OFS_STAT);
      if (rq[3] === 1'b0) break;
    end
    chk_val({31'h0, rq[3]}, 32'h0);
    chk_val({31'h0, BUS_TRANSMIT_PIN}, 32'h0);
    give_verdict();
  end
endmodule // testbench
